// ==== logic/rtcf_pkg.sv ====
// Package: register map, field positions and reset values of the control registers.
package rtcf_pkg;

  // ---------------------------------------------------------------------------
  // Register indices and APB byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RTCF_IDX_CTRL_A    = 8'h0a;
  localparam logic [7:0]  RTCF_IDX_CTRL_B    = 8'h0b;
  localparam logic [7:0]  RTCF_IDX_EVENT     = 8'h0c;
  localparam logic [7:0]  RTCF_IDX_INTEGRITY = 8'h0d;
  localparam int          RTCF_AW            = 12;
  localparam logic [11:0] RTCF_ADDR_CTRL_A    = {2'h0, RTCF_IDX_CTRL_A, 2'h0};
  localparam logic [11:0] RTCF_ADDR_CTRL_B    = {2'h0, RTCF_IDX_CTRL_B, 2'h0};
  localparam logic [11:0] RTCF_ADDR_EVENT     = {2'h0, RTCF_IDX_EVENT, 2'h0};
  localparam logic [11:0] RTCF_ADDR_INTEGRITY = {2'h0, RTCF_IDX_INTEGRITY, 2'h0};

  // ---------------------------------------------------------------------------
  // Control A fields
  // ---------------------------------------------------------------------------
  localparam int RTCF_A_BUSY    = 7;
  localparam int RTCF_A_OSC_HI  = 6;
  localparam int RTCF_A_OSC_LO  = 4;
  localparam int RTCF_A_RATE_HI = 3;
  localparam int RTCF_A_RATE_LO = 0;
  localparam logic [2:0] RTCF_OSC_RW_EVENT = 3'h3;
  localparam logic [2:0] RTCF_OSC_RESET    = 3'h0;
  localparam logic [3:0] RTCF_RATE_RESET   = 4'h0;
  localparam logic [3:0] RTCF_RATE_OFF     = 4'h0;

  // ---------------------------------------------------------------------------
  // Control B fields
  // ---------------------------------------------------------------------------
  localparam int RTCF_B_INHIBIT = 7;
  localparam int RTCF_B_PER_EN  = 6;
  localparam int RTCF_B_ALM_EN  = 5;
  localparam int RTCF_B_UPD_EN  = 4;
  localparam int RTCF_B_SQ_EN   = 3;
  localparam int RTCF_B_DF      = 2;
  localparam int RTCF_B_HF      = 1;
  localparam int RTCF_B_DSE     = 0;
  localparam logic [7:0] RTCF_B_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Event status and integrity fields
  // ---------------------------------------------------------------------------
  localparam int RTCF_C_IRQ      = 7;
  localparam int RTCF_C_PERIODIC = 6;
  localparam int RTCF_C_ALARM    = 5;
  localparam int RTCF_C_UPDATE   = 4;
  localparam int RTCF_C_RAWOSC   = 2;
  localparam int RTCF_D_VALID    = 7;
  localparam logic [7:0] RTCF_C_ZERO_MASK = 8'h0b;
  localparam logic [7:0] RTCF_D_ZERO_MASK = 8'h7f;

endpackage

// ==== logic/rtcf_event_flags.sv ====
// Event status flags, update inhibit and integrity status of the clock peripheral.
// Behaviour
// - Inhibit bit stops buffer copy; clear allows.
// - Setting inhibit bit forces update enable low.
// - Event status normally read-only, ignores writes.
// - Event status bits 0,1,3 read zero.
// - Raw oscillator enable settable only at 011.
// - Other oscillator control values clear raw enable.
// - Square wave and raw enable output oscillator.
// - Update flag sets at update cycle end.
// - Alarm flag sets on alarm match.
// - Periodic flag sets each selected interval.
// - Request flag sets on enabled pending flag.
// - Status read returns flags, then clears them.
// - Integrity register read-only, writes ignored.
// - Integrity bits 0 to 6 read zero.
// - Integrity bit 7 shows backup source validity.
// - Event status writable while oscillator control 011.
// - Update-in-progress held clear while inhibit set.
// - Square wave disabled means output held low.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module rtcf_event_flags
  import rtcf_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [RTCF_AW-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Time base and event sources.
  input  wire logic                 osc_raw,
  input  wire logic [15:0]          divider_taps,
  input  wire logic                 update_start,
  input  wire logic                 update_done,
  input  wire logic                 alarm_match,
  input  wire logic                 backup_valid,
  // Outputs to the clock core and the pins.
  output logic                      buffer_copy_en,
  output logic                      square_wave_out,
  output logic                      irq_n
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [2:0]  oscillator_control_q, oscillator_control_d;
  logic [3:0]  rate_select_q, rate_select_d;
  logic        update_in_progress_q, update_in_progress_d;
  logic [7:0]  ctrl_b_q, ctrl_b_d;
  logic        raw_osc_out_enable_q, raw_osc_out_enable_d;
  logic        update_flag_q, update_flag_d;
  logic        alarm_flag_q, alarm_flag_d;
  logic        periodic_flag_q, periodic_flag_d;
  logic        irq_request_flag_q, irq_request_flag_d;
  logic        tap_prev_q, tap_prev_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        copy_en_q, copy_en_d;
  logic        sq_out_q, sq_out_d;
  logic        irq_n_q, irq_n_d;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic        setup_ph;
  logic        access_wr;
  logic        access_rd;
  logic        hit_a;
  logic        hit_b;
  logic        hit_c;
  logic        hit_d;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [7:0]  event_view;
  logic [7:0]  integrity_view;
  logic [7:0]  ctrl_a_view;
  logic        transfer_inhibit;
  logic        update_irq_enable;
  logic        alarm_irq_enable;
  logic        periodic_irq_enable;
  logic        square_wave_enable;
  logic        tap_sel;
  logic        periodic_tick;
  logic        c_writable;

  // The access phase is one cycle while clk_en is high: pready rises the cycle after setup.
  assign setup_ph  = psel & ~penable;
  assign access_wr = psel & penable & pready_q & pwrite & pstrb[0];
  assign access_rd = psel & penable & pready_q & ~pwrite;
  assign hit_a     = (paddr == RTCF_ADDR_CTRL_A);
  assign hit_b     = (paddr == RTCF_ADDR_CTRL_B);
  assign hit_c     = (paddr == RTCF_ADDR_EVENT);
  assign hit_d     = (paddr == RTCF_ADDR_INTEGRITY);
  assign mapped    = hit_a | hit_b | hit_c | hit_d;
  assign wbyte     = pwdata[7:0];

  assign transfer_inhibit    = ctrl_b_q[RTCF_B_INHIBIT];
  // The interrupt enables come from the next value of control B, so an enable
  // written in the same cycle as an event already raises the request.
  assign update_irq_enable   = ctrl_b_d[RTCF_B_UPD_EN];
  assign alarm_irq_enable    = ctrl_b_d[RTCF_B_ALM_EN];
  assign periodic_irq_enable = ctrl_b_d[RTCF_B_PER_EN];
  assign square_wave_enable  = ctrl_b_q[RTCF_B_SQ_EN];
  assign c_writable = (oscillator_control_q == RTCF_OSC_RW_EVENT);

  // ---------------------------------------------------------------------------
  // Read views
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_a_view = {update_in_progress_q, oscillator_control_q, rate_select_q};
    event_view  = 8'h00;
    event_view[RTCF_C_IRQ]      = irq_request_flag_q;
    event_view[RTCF_C_PERIODIC] = periodic_flag_q;
    event_view[RTCF_C_ALARM]    = alarm_flag_q;
    event_view[RTCF_C_UPDATE]   = update_flag_q;
    event_view[RTCF_C_RAWOSC]   = raw_osc_out_enable_q;
    integrity_view = 8'h00;
    integrity_view[RTCF_D_VALID] = backup_valid;
  end

  // ---------------------------------------------------------------------------
  // Periodic tick from the divider
  // ---------------------------------------------------------------------------
  // Rising edge of the selected divider tap; rate zero selects no tap.
  // Changing the rate while the newly chosen tap is high counts as an edge, so
  // software should clear the flag by a status read after a rate change.
  assign tap_sel       = (rate_select_q == RTCF_RATE_OFF) ? 1'b0 : divider_taps[rate_select_q];
  assign periodic_tick = tap_sel & ~tap_prev_q;

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // Unmapped addresses answer with an error and read as zero.
  always_comb begin
    pready_d  = setup_ph;
    pslverr_d = setup_ph & ~mapped;
    prdata_d  = 32'h0000_0000;
    if (setup_ph && !pwrite) begin
      if (hit_a) begin
        prdata_d[7:0] = ctrl_a_view;
      end else if (hit_b) begin
        prdata_d[7:0] = ctrl_b_q;
      end else if (hit_c) begin
        prdata_d[7:0] = event_view;
      end else if (hit_d) begin
        prdata_d[7:0] = integrity_view;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_comb begin
    oscillator_control_d = oscillator_control_q;
    rate_select_d        = rate_select_q;
    ctrl_b_d             = ctrl_b_q;
    update_in_progress_d = update_in_progress_q;
    if (access_wr && hit_a) begin
      oscillator_control_d = wbyte[RTCF_A_OSC_HI:RTCF_A_OSC_LO];
      rate_select_d        = wbyte[RTCF_A_RATE_HI:RTCF_A_RATE_LO];
    end
    if (access_wr && hit_b) begin
      ctrl_b_d = wbyte;
    end
    if (ctrl_b_d[RTCF_B_INHIBIT]) begin
      ctrl_b_d[RTCF_B_UPD_EN] = 1'b0;
    end
    if (update_start) begin
      update_in_progress_d = 1'b1;
    end
    if (update_done) begin
      update_in_progress_d = 1'b0;
    end
    if (transfer_inhibit) begin
      update_in_progress_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------------
  // A read clears only the bits it actually returned, and a new event in the
  // clearing cycle wins, so no event is ever lost between setup and access.
  always_comb begin
    logic [7:0] clr;
    logic       any_pending;
    clr = 8'h00;
    any_pending = 1'b0;
    if (access_rd && hit_c) begin
      clr = prdata_q[7:0];
    end
    raw_osc_out_enable_d = raw_osc_out_enable_q;
    update_flag_d   = update_flag_q & ~clr[RTCF_C_UPDATE];
    alarm_flag_d    = alarm_flag_q & ~clr[RTCF_C_ALARM];
    periodic_flag_d = periodic_flag_q & ~clr[RTCF_C_PERIODIC];
    irq_request_flag_d = irq_request_flag_q & ~clr[RTCF_C_IRQ];
    if (access_wr && hit_c && c_writable) begin
      raw_osc_out_enable_d = wbyte[RTCF_C_RAWOSC];
      update_flag_d      = wbyte[RTCF_C_UPDATE];
      alarm_flag_d       = wbyte[RTCF_C_ALARM];
      periodic_flag_d    = wbyte[RTCF_C_PERIODIC];
      irq_request_flag_d = wbyte[RTCF_C_IRQ];
    end
    if (oscillator_control_d != RTCF_OSC_RW_EVENT) begin
      raw_osc_out_enable_d = 1'b0;
    end
    if (update_done) begin
      update_flag_d = 1'b1;
    end
    if (alarm_match) begin
      alarm_flag_d = 1'b1;
    end
    if (periodic_tick) begin
      periodic_flag_d = 1'b1;
    end
    any_pending = (alarm_flag_d & alarm_irq_enable)
                | (periodic_flag_d & periodic_irq_enable)
                | (update_flag_d & update_irq_enable);
    if (any_pending) begin
      irq_request_flag_d = 1'b1;
    end
    tap_prev_d = tap_sel;
  end

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    copy_en_d = ~ctrl_b_d[RTCF_B_INHIBIT];
    if (!square_wave_enable) begin
      sq_out_d = 1'b0;
    end else if (raw_osc_out_enable_q) begin
      sq_out_d = osc_raw;
    end else begin
      sq_out_d = tap_sel;
    end
    irq_n_d = ~irq_request_flag_d;
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      oscillator_control_q <= RTCF_OSC_RESET;
      rate_select_q        <= RTCF_RATE_RESET;
      update_in_progress_q <= 1'b0;
      ctrl_b_q             <= RTCF_B_RESET;
      raw_osc_out_enable_q <= 1'b0;
      update_flag_q        <= 1'b0;
      alarm_flag_q         <= 1'b0;
      periodic_flag_q      <= 1'b0;
      irq_request_flag_q   <= 1'b0;
      tap_prev_q           <= 1'b0;
      pready_q             <= 1'b0;
      pslverr_q            <= 1'b0;
      prdata_q             <= 32'h0000_0000;
      copy_en_q            <= 1'b1;
      sq_out_q             <= 1'b0;
      irq_n_q              <= 1'b1;
    end else if (clk_en) begin
      oscillator_control_q <= oscillator_control_d;
      rate_select_q        <= rate_select_d;
      update_in_progress_q <= update_in_progress_d;
      ctrl_b_q             <= ctrl_b_d;
      raw_osc_out_enable_q <= raw_osc_out_enable_d;
      update_flag_q        <= update_flag_d;
      alarm_flag_q         <= alarm_flag_d;
      periodic_flag_q      <= periodic_flag_d;
      irq_request_flag_q   <= irq_request_flag_d;
      tap_prev_q           <= tap_prev_d;
      pready_q             <= pready_d;
      pslverr_q            <= pslverr_d;
      prdata_q             <= prdata_d;
      copy_en_q            <= copy_en_d;
      sq_out_q             <= sq_out_d;
      irq_n_q              <= irq_n_d;
    end
  end

  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign prdata          = prdata_q;
  assign buffer_copy_en  = copy_en_q;
  assign square_wave_out = sq_out_q;
  assign irq_n           = irq_n_q;

endmodule

// ==== tb/rtcf_event_flags_props.sv ====
// Concurrent checks on the ports of the event flag block.
`timescale 1ns/10ps
module rtcf_event_flags_props
  import rtcf_pkg::*;
(
  // Clock and reset.
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               clk_en,
  // APB.
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [RTCF_AW-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  // Sources and pins.
  input wire logic               backup_valid,
  input wire logic               buffer_copy_en,
  input wire logic               square_wave_out,
  input wire logic               irq_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || !clk_en);
  wire acc   = psel & penable & pready;
  wire rd_ev = acc & !pwrite & (paddr == RTCF_ADDR_EVENT);
  wire rd_d  = acc & !pwrite & (paddr == RTCF_ADDR_INTEGRITY);
  wire rd_b  = acc & !pwrite & (paddr == RTCF_ADDR_CTRL_B);
  wire wr_b  = acc & pwrite & pstrb[0] & (paddr == RTCF_ADDR_CTRL_B);
  property p_copy; wr_b |=> buffer_copy_en == !$past(pwdata[RTCF_B_INHIBIT]); endproperty
  property p_uie; rd_b |-> !(prdata[RTCF_B_INHIBIT] && prdata[RTCF_B_UPD_EN]); endproperty
  property p_zero; rd_ev |-> {prdata[31:8], prdata[3], prdata[1:0]} == 27'h0; endproperty
  property p_dzero; rd_d |-> {prdata[31:8], prdata[6:0]} == 31'h0; endproperty
  property p_valid; rd_d |-> prdata[RTCF_D_VALID] == $past(backup_valid); endproperty
  property p_sq; wr_b && !pwdata[RTCF_B_SQ_EN] |=> ##1 !square_wave_out [*2]; endproperty
  property p_irq; rd_ev |-> prdata[RTCF_C_IRQ] == !$past(irq_n); endproperty
  // The pin may only come back high through a status access, never on its own.
  property p_rise; $rose(irq_n) |-> $past(psel && penable && paddr == RTCF_ADDR_EVENT);
  endproperty
  a_copy: assert property (p_copy) else $error("copy enable wrong after write");
  a_uie: assert property (p_uie) else $error("update enable set with inhibit");
  a_zero: assert property (p_zero) else $error("unused status bits not zero");
  a_dzero: assert property (p_dzero) else $error("unused integrity bits set");
  a_valid: assert property (p_valid) else $error("validity bit wrong");
  a_sq: assert property (p_sq) else $error("square wave not held low");
  a_irq: assert property (p_irq) else $error("pin and request flag differ");
  a_rise: assert property (p_rise) else $error("request cleared without read");
  c_irq: cover property (rd_ev && prdata[RTCF_C_IRQ]);
  c_inh: cover property (wr_b && pwdata[RTCF_B_INHIBIT]);
  c_dep: cover property (rd_d && !prdata[RTCF_D_VALID]);
endmodule
bind rtcf_event_flags rtcf_event_flags_props u_props (
  .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .backup_valid(backup_valid), .buffer_copy_en(buffer_copy_en),
  .square_wave_out(square_wave_out), .irq_n(irq_n));

// ==== tb/rtcf_apb_host.sv ====
// Behavioural APB master standing in for the host processor.
`timescale 1ns/10ps
module rtcf_apb_host (
  // Clock.
  input  wire logic        sys_clk,
  // Request.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  // Answer.
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    // Released lines show a changed pattern so stale values cannot pass.
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the event flag block.
`timescale 1ns/10ps
module tb
  import rtcf_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        osc_raw = 1'b0;
  logic [15:0] divider_taps = 16'h0000;
  logic        update_done = 1'b0;
  logic        alarm_match = 1'b0;
  logic        backup_valid = 1'b1;
  logic        update_start = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  rate = 4'h1;
  logic        psel, penable, pwrite, pready, pslverr, err, exp_sq;
  logic        buffer_copy_en, square_wave_out, irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rd;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #4 sys_clk = ~sys_clk;
  rtcf_event_flags u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .osc_raw(osc_raw), .divider_taps(divider_taps),
    .update_start(update_start), .update_done(update_done), .alarm_match(alarm_match),
    .backup_valid(backup_valid), .buffer_copy_en(buffer_copy_en),
    .square_wave_out(square_wave_out), .irq_n(irq_n));
  rtcf_apb_host u_host (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  function automatic logic [7:0] ev_exp(int k, int en);
    return (k == 0 ? 8'h20 : k == 1 ? 8'h10 : 8'h40) | (en != 0 ? 8'h80 : 8'h00);
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rc(input string what, input logic [11:0] a, input logic [7:0] exp);
    u_host.xfer(1'b0, a, 8'h00, rd, err);
    chk(what, rd, exp);
  endtask
  // Taps are pulsed too, so a detector with an extra stage still sees one edge.
  task automatic fire(input int k);
    @(posedge sys_clk);
    alarm_match <= (k == 0);
    update_done <= (k == 1);
    divider_taps <= (k == 2) ? (16'h0001 << rate) : 16'h0000;
    update_start <= (k == 3);
    @(posedge sys_clk);
    alarm_match <= 1'b0;
    update_done <= 1'b0;
    divider_taps <= 16'h0000;
    update_start <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(55610));
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rc("event reset", RTCF_ADDR_EVENT, 8'h00);
    u_host.xfer(1'b0, 12'h000, 8'h00, rd, err);
    chk("unmapped", err, 1'b1);
    fire(3);
    rc("busy set", RTCF_ADDR_CTRL_A, 8'h80);
    wr(RTCF_ADDR_CTRL_B, 8'h90);
    rc("update enable forced", RTCF_ADDR_CTRL_B, 8'h80);
    chk("copy off", buffer_copy_en, 1'b0);
    rc("busy cleared", RTCF_ADDR_CTRL_A, 8'h00);
    fire(3);
    rc("busy held clear", RTCF_ADDR_CTRL_A, 8'h00);
    wr(RTCF_ADDR_CTRL_B, 8'h00);
    rc("inhibit off", RTCF_ADDR_CTRL_B, 8'h00);
    chk("copy on", buffer_copy_en, 1'b1);
    $display("test inhibit done");
    for (int en = 0; en < 2; en++) begin
      rate = 4'(1 + $urandom % 15);
      wr(RTCF_ADDR_CTRL_A, {4'h2, rate});
      wr(RTCF_ADDR_CTRL_B, en != 0 ? 8'h70 : 8'h00);
      for (int k = 0; k < 3; k++) begin
        fire(k);
        chk("irq pin", irq_n, en == 0);
        rc("flags", RTCF_ADDR_EVENT, ev_exp(k, en));
        @(negedge sys_clk);
        chk("irq released", irq_n, 1'b1);
        rc("flags cleared", RTCF_ADDR_EVENT, 8'h00);
      end
    end
    rate = 4'h0;
    wr(RTCF_ADDR_CTRL_A, 8'h20);
    fire(2);
    rc("no tap at rate zero", RTCF_ADDR_EVENT, 8'h00);
    clk_en <= 1'b0;
    fire(0);
    clk_en <= 1'b1;
    rc("frozen flags", RTCF_ADDR_EVENT, 8'h00);
    chk("frozen pin", irq_n, 1'b1);
    $display("test events done");
    wr(RTCF_ADDR_EVENT, 8'hf4);
    rc("event write ignored", RTCF_ADDR_EVENT, 8'h00);
    wr(RTCF_ADDR_CTRL_A, 8'h31);
    wr(RTCF_ADDR_EVENT, 8'h04);
    rc("raw enable set", RTCF_ADDR_EVENT, 8'h04);
    wr(RTCF_ADDR_CTRL_B, 8'h08);
    @(posedge sys_clk);
    exp_sq = osc_raw;
    repeat (8) begin
      @(posedge sys_clk);
      chk("raw osc out", square_wave_out, exp_sq);
      exp_sq = osc_raw;
      osc_raw <= 1'($urandom);
    end
    wr(RTCF_ADDR_CTRL_B, 8'h00);
    repeat (2) @(posedge sys_clk);
    repeat (8) begin
      @(posedge sys_clk);
      chk("held low", square_wave_out, 1'b0);
      osc_raw <= 1'($urandom);
    end
    wr(RTCF_ADDR_CTRL_A, 8'h21);
    rc("raw enable cleared", RTCF_ADDR_EVENT, 8'h00);
    $display("test oscillator done");
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      backup_valid <= (i == 1) ? 1'b0 : 1'($urandom);
      wr(RTCF_ADDR_INTEGRITY, 8'hff);
      rc("integrity", RTCF_ADDR_INTEGRITY, {backup_valid, 7'h00});
    end
    $display("test integrity done");
    print_verdict();
  end
endmodule
